// *** rtl/ths_task_handshake.sv ***
// Host handshake bits, task launch and module reset sequencing.
//
// The Wishbone register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// (R1) In run mode, raise task-run-ready once multitask execution is enabled.
// (R2) Host reset request drops task-run-ready.
// (R3) Host transfers inside the post-request access window raise no error.
// (R4) After reset processing and re-enable, task-run-ready rises again.
// (R5) Ready, error and system-down flags act only in run modes 0 and 1.
// (R6) Program error raises its flag, lamp, stores line and code, halts.
// (R7) Program error flag high forces task-run-ready low.
// (R8) System down raises its flag, lamp and stores the error code.
// (R9) System down flag high forces task-run-ready low.
// (R10) Operating status is low while off and during reset processing.
// (R11) Twenty-three host general output bits are readable by the program.
// (R12) Two select bits; a non-interrupt task's select is a general output.
// (R13) Launch strobe rising edge starts each selected host-interrupt task.
// (R14) Selects rising while the strobe is already high are ignored.
// (R15) A selected task already running or starting is left alone.
// (R16) Launch acts only while ready; it is never a general output.
// (R17) Host keeps a select high until it sees the task started.
// (R18) Reset request resets this module only, after a 200 or 2000 ms window.
// (R19) Host interlocks its accesses on the operating status flag.
// (R20) Tasks default to start-by-other-task with preloaded program.
// (R21) Compiled tasks are never started by the host launch.
// (R22) Tasks with no start condition never get a program read.
// (R23) Host pins are synchronised and the strobe edge found from two samples.
module ths_task_handshake
  import ths_pkg::*;
#(
  parameter int unsigned WIN_SHORT_CYC = THS_WIN_SHORT_CYC,
  parameter int unsigned WIN_LONG_CYC = THS_WIN_LONG_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [THS_NGEN-1:0] general_out_i,
  input wire logic [THS_NTASK-1:0] task_select_i,
  input wire logic task_launch_i,
  input wire logic module_reset_request_i,
  input wire logic host_access_i,
  output logic task_run_ready_o,
  output logic program_error_flag_o,
  output logic system_down_flag_o,
  output logic module_alive_o,
  output logic err_lamp_o,
  output logic access_error_o,
  output logic [THS_NTASK-1:0] task_start_o,
  output logic [THS_NTASK-1:0] prog_load_o
);

  function automatic logic [31:0] byte_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic ths_cond_t task_cond(input logic [31:0] cfg,
                                          input int t);
    logic [2:0] c;
    c = cfg[THS_COND_W*t +: 3];
    return ths_cond_t'(c);
  endfunction

  // Pin synchroniser: three stages and a two-sample agreement filter.
  logic [THS_PIN_W-1:0] pin_raw;
  logic [THS_PIN_W-1:0] s1_q, s2_q, s3_q, flt_q, flt_d;
  logic [THS_PIN_W-1:0] s1_d, s2_d, s3_d;

  assign pin_raw = {host_access_i, module_reset_request_i, task_launch_i,
                    task_select_i, general_out_i};

  // (R23) Sync and filter.
  always_comb begin
    s1_d = pin_raw;
    s2_d = s1_q;
    s3_d = s2_q;
    flt_d = ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & flt_q);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      flt_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      flt_q <= flt_d;
    end
  end

  logic launch_rise, rstreq_rise, access_rise;
  logic [THS_NTASK-1:0] sel_now;

  // (R23) Edge from two consecutive filtered samples.
  assign launch_rise = flt_d[THS_PIN_LAUNCH] & ~flt_q[THS_PIN_LAUNCH];
  assign rstreq_rise = flt_d[THS_PIN_RSTREQ] & ~flt_q[THS_PIN_RSTREQ];
  assign access_rise = flt_d[THS_PIN_ACCESS] & ~flt_q[THS_PIN_ACCESS];
  // (R14) Selects only sampled at the strobe edge.
  assign sel_now = flt_d[THS_PIN_SEL +: THS_NTASK];

  // Wishbone slave and software registers.
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] cfg_q, cfg_d;
  logic [31:0] stage_q, stage_d;
  logic [31:0] cmd_pulse;
  logic [13:0] idx;
  logic wr_go, rd_go;

  ths_state_t st_q, st_d;
  logic perr_q, perr_d, sdown_q, sdown_d, lamp_q, lamp_d;
  logic [15:0] eline_q, eline_d, ecode_q, ecode_d;
  logic [31:0] cnt_q, cnt_d;
  logic [THS_NTASK-1:0] busy_q, busy_d, start_q, start_d, load_q, load_d;
  logic rdy_q, rdy_d, pe_o_q, pe_o_d, sd_o_q, sd_o_d;
  logic alive_q, alive_d, lamp_o_q, lamp_o_d, aerr_q, aerr_d;
  logic [THS_NTASK+THS_NGEN-1:0] genout;

  assign idx = wb_adr_i[15:2];
  assign wr_go = wb_cyc_i & wb_stb_i & ack_q & wb_we_i;
  assign rd_go = wb_cyc_i & wb_stb_i & ~ack_q & ~wb_we_i;

  // (R12) Selects of non-interrupt tasks read back as general outputs.
  always_comb begin
    genout = {{THS_NTASK{1'b0}}, flt_q[THS_NGEN-1:0]};
    for (int t = 0; t < THS_NTASK; t++) begin
      if (task_cond(cfg_q, t) != THS_COND_IT) begin
        genout[THS_NGEN+t] = flt_q[THS_PIN_SEL+t];
      end
    end
  end

  always_comb begin
    ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
    ctrl_d = ctrl_q;
    cfg_d = cfg_q;
    stage_d = stage_q;
    cmd_pulse = '0;
    rdat_d = rdat_q;
    if (wr_go) begin
      case (idx)
        THS_IDX_CTRL: begin
          ctrl_d = byte_merge(ctrl_q, wb_dat_i, wb_sel_i) & THS_CTRL_MASK;
        end
        THS_IDX_TASKCFG: begin
          cfg_d = byte_merge(cfg_q, wb_dat_i, wb_sel_i) & THS_TASKCFG_MASK;
        end
        THS_IDX_CMD: begin
          cmd_pulse = byte_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
        end
        THS_IDX_ERRSTAGE: begin
          stage_d = byte_merge(stage_q, wb_dat_i, wb_sel_i);
        end
        default: begin
        end
      endcase
    end
    if (rd_go) begin
      case (idx)
        THS_IDX_CTRL: rdat_d = ctrl_q;
        THS_IDX_TASKCFG: rdat_d = cfg_q;
        THS_IDX_ERRSTAGE: rdat_d = stage_q;
        THS_IDX_STATUS: begin
          rdat_d = {16'h0000, 2'h0, st_q, busy_q, lamp_q, alive_q,
                    sd_o_q, pe_o_q, rdy_q, sdown_q, perr_q};
        end
        // (R11) General output bits for the program.
        THS_IDX_GENOUT: rdat_d = {7'h00, genout};
        THS_IDX_ERR_LINE: rdat_d = {16'h0000, eline_q};
        THS_IDX_ERR_CODE: rdat_d = {16'h0000, ecode_q};
        default: rdat_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      ctrl_q <= THS_CTRL_RST;
      // (R20) Default start by another task.
      cfg_q <= THS_TASKCFG_RST;
      stage_q <= 32'h0000_0000;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      ctrl_q <= ctrl_d;
      cfg_q <= cfg_d;
      stage_q <= stage_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // Module control sequence.
  logic run_mode_d, mt_en;
  logic [THS_NTASK-1:0] compiled;

  assign mt_en = ctrl_q[THS_CTRL_MTEN];
  assign compiled = ctrl_q[THS_CTRL_COMP_LSB +: THS_NTASK];
  // (R5) Run mode is switch setting 0 or 1.
  assign run_mode_d = (ctrl_d[THS_CTRL_MODE_LSB +: 2] == 2'h0) |
                      (ctrl_d[THS_CTRL_MODE_LSB +: 2] == 2'h1);

  always_comb begin
    st_d = st_q;
    perr_d = perr_q;
    sdown_d = sdown_q;
    lamp_d = lamp_q;
    eline_d = eline_q;
    ecode_d = ecode_q;
    cnt_d = cnt_q;
    start_d = '0;
    load_d = '0;
    aerr_d = 1'b0;
    // Busy clears on the task's end; a start in the same cycle wins.
    busy_d = busy_q & ~cmd_pulse[THS_CMD_END_LSB +: THS_NTASK];
    case (st_q)
      THS_ST_BOOT: begin
        // (R1) Multitask enable brings the module to run.
        if (mt_en) begin
          st_d = THS_ST_RUN;
          for (int t = 0; t < THS_NTASK; t++) begin
            // (R22) No program read for unconfigured tasks.
            load_d[t] = task_cond(cfg_q, t) != THS_COND_OFF &&
                        task_cond(cfg_q, t) != THS_COND_ON;
            if (task_cond(cfg_q, t) == THS_COND_START) begin
              start_d[t] = 1'b1;
              busy_d[t] = 1'b1;
            end
          end
        end
      end
      THS_ST_RUN: begin
        if (cmd_pulse[THS_CMD_PERR]) begin
          // (R6) Program error: flag, lamp, line and code, halt.
          perr_d = 1'b1;
          lamp_d = 1'b1;
          eline_d = stage_q[15:0];
          ecode_d = stage_q[31:16];
          st_d = THS_ST_HALT;
        end else if (cmd_pulse[THS_CMD_SDOWN]) begin
          // (R8) System down: flag, lamp and code.
          sdown_d = 1'b1;
          lamp_d = 1'b1;
          ecode_d = stage_q[31:16];
          st_d = THS_ST_HALT;
        end else if (launch_rise && !rdy_q) begin
          // (R16) Launch ignored unless ready.
          start_d = '0;
        end else if (launch_rise) begin
          for (int t = 0; t < THS_NTASK; t++) begin
            // (R13) Start selected interrupt tasks; (R21) not compiled.
            // (R15) A busy task is left running.
            if (sel_now[t] && task_cond(cfg_q, t) == THS_COND_IT &&
                !compiled[t] && !busy_q[t]) begin
              start_d[t] = 1'b1;
              busy_d[t] = 1'b1;
            end
          end
        end
      end
      THS_ST_HALT: begin
      end
      THS_ST_WINDOW: begin
        // (R18) Reset follows the access window.
        if (cnt_q <= 32'h0000_0001) begin
          st_d = THS_ST_RESET;
          cnt_d = THS_RESET_PROC_CYC;
        end else begin
          cnt_d = cnt_q - 32'h0000_0001;
        end
      end
      THS_ST_RESET: begin
        // (R4) Reset done; ready returns through the boot state.
        if (cnt_q <= 32'h0000_0001) begin
          st_d = THS_ST_BOOT;
          perr_d = 1'b0;
          sdown_d = 1'b0;
          lamp_d = 1'b0;
          busy_d = '0;
        end else begin
          cnt_d = cnt_q - 32'h0000_0001;
        end
      end
      default: begin
        st_d = THS_ST_BOOT;
      end
    endcase
    // (R18) A reset request opens the access window.
    if (rstreq_rise && st_q != THS_ST_WINDOW && st_q != THS_ST_RESET) begin
      st_d = THS_ST_WINDOW;
      start_d = '0;
      load_d = '0;
      cnt_d = ctrl_q[THS_CTRL_WLONG] ? WIN_LONG_CYC : WIN_SHORT_CYC;
    end
    // (R3) Accesses in the window are not errors.
    if (access_rise && !rdy_q && st_q != THS_ST_WINDOW) begin
      aerr_d = 1'b1;
    end
    // (R2) (R7) (R9) Ready only in run without error flags.
    // (R5) Flags gated by run mode.
    rdy_d = (st_d == THS_ST_RUN) && run_mode_d && !perr_d && !sdown_d;
    pe_o_d = perr_d && run_mode_d;
    sd_o_d = sdown_d && run_mode_d;
    // (R10) Low during reset processing.
    alive_d = st_d != THS_ST_RESET;
    lamp_o_d = lamp_d;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= THS_ST_BOOT;
      perr_q <= 1'b0;
      sdown_q <= 1'b0;
      lamp_q <= 1'b0;
      eline_q <= 16'h0000;
      ecode_q <= 16'h0000;
      cnt_q <= 32'h0000_0000;
      busy_q <= '0;
      start_q <= '0;
      load_q <= '0;
      rdy_q <= 1'b0;
      pe_o_q <= 1'b0;
      sd_o_q <= 1'b0;
      alive_q <= 1'b0;
      lamp_o_q <= 1'b0;
      aerr_q <= 1'b0;
    end else begin
      st_q <= st_d;
      perr_q <= perr_d;
      sdown_q <= sdown_d;
      lamp_q <= lamp_d;
      eline_q <= eline_d;
      ecode_q <= ecode_d;
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      start_q <= start_d;
      load_q <= load_d;
      rdy_q <= rdy_d;
      pe_o_q <= pe_o_d;
      sd_o_q <= sd_o_d;
      alive_q <= alive_d;
      lamp_o_q <= lamp_o_d;
      aerr_q <= aerr_d;
    end
  end

  assign task_run_ready_o = rdy_q;
  assign program_error_flag_o = pe_o_q;
  assign system_down_flag_o = sd_o_q;
  assign module_alive_o = alive_q;
  assign err_lamp_o = lamp_o_q;
  assign access_error_o = aerr_q;
  assign task_start_o = start_q;
  assign prog_load_o = load_q;

endmodule

`default_nettype wire

// *** pkg/ths_pkg.sv ***
// Constants and types shared by the task handshake block.
package ths_pkg;

  localparam int unsigned THS_CLK_KHZ = 250000;
  localparam int unsigned THS_WIN_SHORT_MS = 200;
  localparam int unsigned THS_WIN_LONG_MS = 2000;
  localparam int unsigned THS_WIN_SHORT_CYC = THS_WIN_SHORT_MS * THS_CLK_KHZ;
  localparam int unsigned THS_WIN_LONG_CYC = THS_WIN_LONG_MS * THS_CLK_KHZ;
  localparam logic [31:0] THS_RESET_PROC_CYC = 32'h0000_0010;

  localparam int THS_NTASK = 2;
  localparam int THS_NGEN = 23;
  localparam int THS_PIN_W = 28;
  localparam int THS_PIN_SEL = 23;
  localparam int THS_PIN_LAUNCH = 25;
  localparam int THS_PIN_RSTREQ = 26;
  localparam int THS_PIN_ACCESS = 27;

  localparam logic [13:0] THS_IDX_CTRL = 14'h0000;
  localparam logic [13:0] THS_IDX_TASKCFG = 14'h0001;
  localparam logic [13:0] THS_IDX_CMD = 14'h0002;
  localparam logic [13:0] THS_IDX_ERRSTAGE = 14'h0003;
  localparam logic [13:0] THS_IDX_STATUS = 14'h0004;
  localparam logic [13:0] THS_IDX_GENOUT = 14'h0005;
  localparam logic [13:0] THS_IDX_ERR_LINE = 14'h2400;
  localparam logic [13:0] THS_IDX_ERR_CODE = 14'h2401;

  localparam int THS_CTRL_MODE_LSB = 0;
  localparam int THS_CTRL_MTEN = 2;
  localparam int THS_CTRL_WLONG = 3;
  localparam int THS_CTRL_COMP_LSB = 4;
  localparam logic [31:0] THS_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] THS_CTRL_MASK = 32'h0000_003F;

  localparam int THS_CMD_PERR = 0;
  localparam int THS_CMD_SDOWN = 1;
  localparam int THS_CMD_END_LSB = 2;

  localparam int THS_COND_W = 4;
  localparam logic [31:0] THS_TASKCFG_MASK = 32'h0000_0077;

  typedef enum logic [2:0] {
    THS_COND_START = 3'h0,
    THS_COND_IT = 3'h1,
    THS_COND_BOOT = 3'h2,
    THS_COND_ON = 3'h3,
    THS_COND_OFF = 3'h4
  } ths_cond_t;

  localparam logic [31:0] THS_TASKCFG_RST = 32'h0000_0022;

  typedef enum logic [4:0] {
    THS_ST_BOOT = 5'b00001,
    THS_ST_RUN = 5'b00010,
    THS_ST_HALT = 5'b00100,
    THS_ST_WINDOW = 5'b01000,
    THS_ST_RESET = 5'b10000
  } ths_state_t;

endpackage

// *** tb/ths_host_model.sv ***
// Host controller model that drives the handshake pins.
`timescale 1ns/1ns
`default_nettype none
module ths_host_model
  import ths_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic alive_i,
  input wire logic [THS_NTASK-1:0] start_i,
  input wire logic [THS_NTASK-1:0] sel_req_i,
  input wire logic launch_req_i,
  input wire logic rst_req_i,
  input wire logic acc_req_i,
  output logic [THS_NTASK-1:0] sel_o,
  output logic launch_o,
  output logic rst_req_o,
  output logic acc_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_o <= '0;
      launch_o <= 1'b0;
      rst_req_o <= 1'b0;
      acc_o <= 1'b0;
    end else begin
      sel_o <= sel_req_i | (sel_o & ~start_i);
      launch_o <= launch_req_i;
      rst_req_o <= rst_req_i;
      acc_o <= acc_req_i & alive_i;
    end
  end
endmodule
`default_nettype wire

// *** tb/ths_task_handshake_assertions.sv ***
// Checker for the task handshake port behaviour.
`timescale 1ns/1ns
`default_nettype none
module ths_chk
  import ths_pkg::*;
#(
  parameter int unsigned WIN_SHORT_CYC = 40
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic module_reset_request_i,
  input wire logic task_run_ready_o,
  input wire logic program_error_flag_o,
  input wire logic system_down_flag_o,
  input wire logic module_alive_o,
  input wire logic err_lamp_o,
  input wire logic [THS_NTASK-1:0] task_start_o
);
  logic rq_q;
  logic rq_d;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  always_comb begin
    rq_d = module_reset_request_i;
    cnt_d = cnt_q;
    if (module_reset_request_i && !rq_q) begin
      cnt_d = 32'h0;
    end else if (cnt_q != 32'hFFFF_FFFF) begin
      cnt_d = cnt_q + 32'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rq_q <= 1'b0;
      cnt_q <= 32'h0;
    end else begin
      rq_q <= rq_d;
      cnt_q <= cnt_d;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_low8; !module_alive_o [*8]; endsequence
  property p_perr_ready;
    program_error_flag_o |-> !task_run_ready_o;
  endproperty
  a_perr_ready: assert property (p_perr_ready)
    else $error("ready high with program error");
  property p_sd_ready; system_down_flag_o |-> !task_run_ready_o; endproperty
  a_sd_ready: assert property (p_sd_ready)
    else $error("ready high with system down");
  property p_perr_lamp; $rose(program_error_flag_o) |-> err_lamp_o; endproperty
  a_perr_lamp: assert property (p_perr_lamp)
    else $error("lamp off on program error");
  property p_sd_lamp; $rose(system_down_flag_o) |-> err_lamp_o; endproperty
  a_sd_lamp: assert property (p_sd_lamp)
    else $error("lamp off on system down");
  property p_rq_ready;
    $rose(module_reset_request_i) && task_run_ready_o |->
      ##[1:8] !task_run_ready_o;
  endproperty
  a_rq_ready: assert property (p_rq_ready)
    else $error("ready kept after reset request");
  property p_rst_len;
    $fell(module_alive_o) |-> s_low8 ##1 s_low8 ##[1:5] module_alive_o;
  endproperty
  a_rst_len: assert property (p_rst_len)
    else $error("operating status low for wrong span");
  property p_win; $fell(module_alive_o) |-> cnt_q >= WIN_SHORT_CYC; endproperty
  a_win: assert property (p_win)
    else $error("reset before access window ended");
  property p_st_ready;
    |task_start_o |-> !program_error_flag_o && !system_down_flag_o;
  endproperty
  a_st_ready: assert property (p_st_ready)
    else $error("task started while not ready");
  property p_st_once; task_start_o[0] |=> !task_start_o[0]; endproperty
  a_st_once: assert property (p_st_once)
    else $error("running task started again");
endmodule
`default_nettype wire

// *** tb/ths_task_handshake_tb_top.sv ***
// Testbench for the task handshake block.
`timescale 1ns/1ns
`default_nettype none
module ths_task_handshake_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [15:0] wb_adr_i = 16'h0000;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, rdat, wb_dat_o;
  logic [22:0] general_out_i = 23'h0;
  logic [1:0] sel_req = 2'h0, task_select_i, task_start_o, prog_load_o;
  logic launch_req = 1'b0, rst_req = 1'b0, acc_req = 1'b0;
  logic wb_ack_o, task_run_ready_o, program_error_flag_o, system_down_flag_o;
  logic module_alive_o, err_lamp_o, access_error_o;
  logic task_launch_i, module_reset_request_i, host_access_i;
  int mismatches = 0, samples_checked = 0, starts = 0, acc_errs = 0, n;
  int lds = 0;
  always #2 clk_i = ~clk_i;
  ths_task_handshake #(.WIN_SHORT_CYC(40), .WIN_LONG_CYC(80))
  u_ths_task_handshake (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .general_out_i,
    .task_select_i, .task_launch_i, .module_reset_request_i, .host_access_i,
    .task_run_ready_o, .program_error_flag_o, .system_down_flag_o,
    .module_alive_o, .err_lamp_o, .access_error_o, .task_start_o,
    .prog_load_o);
  ths_host_model u_ths_host_model (.clk_i, .rst_i, .alive_i(module_alive_o),
    .start_i(task_start_o), .sel_req_i(sel_req), .launch_req_i(launch_req),
    .rst_req_i(rst_req), .acc_req_i(acc_req), .sel_o(task_select_i),
    .launch_o(task_launch_i), .rst_req_o(module_reset_request_i),
    .acc_o(host_access_i));
  always @(posedge clk_i) begin
    starts <= starts + (task_start_o[0] === 1'b1) + (task_start_o[1] === 1'b1);
    lds <= lds + (prog_load_o[0] === 1'b1) + (prog_load_o[1] === 1'b1);
    if (access_error_o === 1'b1) acc_errs <= acc_errs + 1;
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [15:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int k;
    k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    if (k >= 50) mismatches++;
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hF);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hF);
    check(rdat, e);
  endtask
  task automatic pulse_launch(input int e);
    int s0;
    s0 = starts;
    launch_req <= 1'b1;
    repeat (12) @(posedge clk_i);
    launch_req <= 1'b0;
    repeat (12) @(posedge clk_i);
    check(32'(starts - s0), 32'(e));
  endtask
  task automatic wait_alive(input logic v, output int k);
    k = 0;
    while (module_alive_o !== v && k < 300) begin
      @(posedge clk_i);
      k++;
    end
  endtask
  task automatic reset_seq(input int win);
    int k;
    int e0;
    e0 = acc_errs;
    rst_req <= 1'b1;
    repeat (12) @(posedge clk_i);
    check(32'(task_run_ready_o), 32'h0);
    acc_req <= 1'b1;
    repeat (6) @(posedge clk_i);
    acc_req <= 1'b0;
    wait_alive(1'b0, k);
    check(32'(k + 18 >= win + 2 && k + 18 <= win + 10), 32'h1);
    check(32'(acc_errs - e0), 32'h0);
    wait_alive(1'b1, k);
    check(32'(k >= 14 && k <= 18), 32'h1);
    rst_req <= 1'b0;
    repeat (4) @(posedge clk_i);
    check(32'(task_run_ready_o), 32'h1);
  endtask
  initial begin
    #20000;
    mismatches++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(16'h0000, 32'h0);
    rd(16'h0004, 32'h22);
    rd(16'h0100, 32'h0);
    check(32'(task_run_ready_o), 32'h0);
    wr(16'h0004, 32'h21);
    wr(16'h0000, 32'h4);
    repeat (3) @(posedge clk_i);
    check(32'(task_run_ready_o), 32'h1);
    check(32'(lds), 32'h2);
    general_out_i <= 23'h5A5A5A;
    sel_req <= 2'b10;
    repeat (10) @(posedge clk_i);
    rd(16'h0014, {7'h0, 2'b10, 23'h5A5A5A});
    launch_req <= 1'b1;
    repeat (10) @(posedge clk_i);
    n = starts;
    sel_req <= 2'b11;
    repeat (12) @(posedge clk_i);
    check(32'(starts - n), 32'h0);
    launch_req <= 1'b0;
    repeat (8) @(posedge clk_i);
    pulse_launch(1);
    pulse_launch(0);
    wr(16'h0008, 32'h4);
    pulse_launch(1);
    wr(16'h0008, 32'h4);
    sel_req <= 2'b10;
    wr(16'h0000, 32'h14);
    pulse_launch(0);
    wr(16'h0000, 32'h6);
    repeat (2) @(posedge clk_i);
    check(32'(task_run_ready_o), 32'h0);
    pulse_launch(0);
    wr(16'h0000, 32'h5);
    repeat (2) @(posedge clk_i);
    check(32'(task_run_ready_o), 32'h1);
    reset_seq(40);
    wr(16'h000C, 32'h00AB0123);
    wb(1'b1, 16'h000C, 32'hFFFF4567, 4'h3);
    rd(16'h000C, 32'h00AB4567);
    wr(16'h0008, 32'h1);
    repeat (2) @(posedge clk_i);
    check({29'h0, program_error_flag_o, err_lamp_o, task_run_ready_o},
          32'h6);
    rd(16'h9000, 32'h4567);
    rd(16'h9004, 32'hAB);
    pulse_launch(0);
    wr(16'h0000, 32'hD);
    wr(16'h0004, 32'h41);
    reset_seq(80);
    check(32'(lds), 32'h5);
    wr(16'h000C, 32'h00CD0000);
    wr(16'h0008, 32'h2);
    repeat (2) @(posedge clk_i);
    check({29'h0, system_down_flag_o, err_lamp_o, task_run_ready_o},
          32'h6);
    rd(16'h9004, 32'hCD);
    stop_test();
  end
endmodule
bind ths_task_handshake ths_chk #(.WIN_SHORT_CYC(WIN_SHORT_CYC)) u_ths_chk (
  .clk_i, .rst_i, .module_reset_request_i, .task_run_ready_o,
  .program_error_flag_o, .system_down_flag_o, .module_alive_o,
  .err_lamp_o, .task_start_o);
`default_nettype wire
